// ===== fdd_pkg.sv
/*
  Package for the four-digit display write port: code values, segment patterns,
  backplane timing. Assumes a 50 MHz core clock.
*/
package fdd_pkg;

  // ==========================================================================
  // Sizes
  localparam int unsigned CODE_W = 4;
  localparam int unsigned SEL_W = 2;
  localparam int unsigned SEG_W = 7;
  localparam int unsigned NUM_DIGITS = 4;

  // ==========================================================================
  // Special codes
  localparam logic [3:0] CODE_DASH = 4'hA;
  localparam logic [3:0] CODE_E = 4'hB;
  localparam logic [3:0] CODE_L = 4'hC;
  localparam logic [3:0] CODE_P = 4'hD;
  localparam logic [3:0] CODE_H = 4'hE;
  localparam logic [3:0] CODE_BLANK = 4'hF;
  localparam logic [3:0] CODE_RESET = CODE_BLANK;

  // ==========================================================================
  // Segment patterns, bit 6 = a ... bit 0 = g
  localparam logic [6:0] SEG_0 = 7'h7E;
  localparam logic [6:0] SEG_1 = 7'h30;
  localparam logic [6:0] SEG_2 = 7'h6D;
  localparam logic [6:0] SEG_3 = 7'h79;
  localparam logic [6:0] SEG_4 = 7'h33;
  localparam logic [6:0] SEG_5 = 7'h5B;
  localparam logic [6:0] SEG_6 = 7'h5F;
  localparam logic [6:0] SEG_7 = 7'h70;
  localparam logic [6:0] SEG_8 = 7'h7F;
  localparam logic [6:0] SEG_9 = 7'h73;
  localparam logic [6:0] SEG_DASH = 7'h01;
  localparam logic [6:0] SEG_E = 7'h4F;
  localparam logic [6:0] SEG_L = 7'h0E;
  localparam logic [6:0] SEG_P = 7'h67;
  localparam logic [6:0] SEG_H = 7'h37;
  localparam logic [6:0] SEG_OFF = 7'h00;

  // ==========================================================================
  // Backplane timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned BP_HALF_US = 10_000;
  localparam int unsigned BP_HALF_CYC = BP_HALF_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BP_CNT_W = 20;

endpackage : fdd_pkg

// ===== fdd_write_port.sv
/*
  Four-digit seven-segment driver with a write-only host port and an LCD
  backplane that can run free or follow a master driver's backplane.
  Assumes host pins are asynchronous to core_clk_in and are synchronised here;
  the host holds data and selects stable around the chip-select window.
*/
`timescale 1ns/100ps

// Notes on behaviour
// RL1 - The 4-bit code arrives on four data pins, lowest pin least significant.
// RL2 - Codes zero to nine show the matching decimal numeral.
// RL3 - Codes ten to fourteen show dash, E, L, P and H in that order.
// RL4 - Code fifteen turns every segment of that digit off.
// RL5 - The two digit-select pins choose which of the four digit latches is written.
// RL6 - The two active-low chip selects are interchangeable and data is taken only while both are low.
// RL7 - The host drives the low digit select from address bit zero and the high one from address bit one.
// RL8 - The host drives one chip select from its write strobe and the other from an address decoder.
// RL9 - The host updates a digit with one write to one of four consecutive locations.
// RL10 - Segment drive follows the backplane phase so no steady DC appears across the glass.
// RL11 - The backplane can be slaved to another driver's backplane to keep drivers in phase.
// RL12 - Each digit latch holds its code and its pattern is driven until rewritten.
// RL13 - Seven segment outputs a to g exist for each of four digits, digit one least significant.
module fdd_write_port (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic code_in_lsb,
  input wire logic code_in_b1,
  input wire logic code_in_b2,
  input wire logic code_in_msb,
  input wire logic digit_sel_low,
  input wire logic digit_sel_high,
  input wire logic chip_sel_n_a,
  input wire logic chip_sel_n_b,
  input wire logic bp_slave_in,
  input wire logic bp_ext_in,
  output logic bp_out,
  output logic [6:0] seg_d1_out,
  output logic [6:0] seg_d2_out,
  output logic [6:0] seg_d3_out,
  output logic [6:0] seg_d4_out
);

  // ==========================================================================
  // Input synchronisers
  localparam int unsigned SYNC_W = 10;
  // Chip selects idle high, backplane pins low: no false write or backplane edge after reset
  localparam logic [SYNC_W-1:0] SYNC_RST = 10'h0C0;
  logic [SYNC_W-1:0] meta_ff;
  logic [SYNC_W-1:0] sync_ff;
  logic [SYNC_W-1:0] raw_pins;
  assign raw_pins = {bp_ext_in, bp_slave_in, chip_sel_n_b, chip_sel_n_a, digit_sel_high,
                     digit_sel_low, code_in_msb, code_in_b2, code_in_b1, code_in_lsb};

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_ff <= SYNC_RST;
      sync_ff <= SYNC_RST;
    end
    else
    begin
      meta_ff <= raw_pins;
      sync_ff <= meta_ff;
    end
  end

  wire logic [3:0] code_s = sync_ff[3:0]; // RL1
  wire logic [1:0] sel_s = sync_ff[5:4]; // RL5
  wire logic sel_active = ~sync_ff[6] & ~sync_ff[7]; // RL6
  wire logic slave_s = sync_ff[8];
  wire logic ext_bp_s = sync_ff[9];

  // ==========================================================================
  // Digit latches
  logic [3:0] code_ff [fdd_pkg::NUM_DIGITS];
  logic [3:0] wr_dec;
  assign wr_dec = sel_active ? (4'h1 << sel_s) : 4'h0; // RL5

  genvar gi;
  generate
    for (gi = 0; gi < fdd_pkg::NUM_DIGITS; gi++)
    begin : g_dig
      always_ff @(posedge core_clk_in or posedge rst_in)
      begin
        if (rst_in)
          code_ff[gi] <= fdd_pkg::CODE_RESET;
        else if (wr_dec[gi])
          code_ff[gi] <= code_s; // RL12
      end
    end
  endgenerate

  // ==========================================================================
  // Decoder
  function automatic logic [6:0] fdd_decode(input logic [3:0] c);
    logic [6:0] s;
    s = fdd_pkg::SEG_OFF;
    unique case (c)
      4'h0: s = fdd_pkg::SEG_0; // RL2
      4'h1: s = fdd_pkg::SEG_1;
      4'h2: s = fdd_pkg::SEG_2;
      4'h3: s = fdd_pkg::SEG_3;
      4'h4: s = fdd_pkg::SEG_4;
      4'h5: s = fdd_pkg::SEG_5;
      4'h6: s = fdd_pkg::SEG_6;
      4'h7: s = fdd_pkg::SEG_7;
      4'h8: s = fdd_pkg::SEG_8;
      4'h9: s = fdd_pkg::SEG_9;
      fdd_pkg::CODE_DASH: s = fdd_pkg::SEG_DASH; // RL3
      fdd_pkg::CODE_E: s = fdd_pkg::SEG_E;
      fdd_pkg::CODE_L: s = fdd_pkg::SEG_L;
      fdd_pkg::CODE_P: s = fdd_pkg::SEG_P;
      fdd_pkg::CODE_H: s = fdd_pkg::SEG_H;
      fdd_pkg::CODE_BLANK: s = fdd_pkg::SEG_OFF; // RL4
    endcase
    return s;
  endfunction : fdd_decode

  // ==========================================================================
  // Backplane: free-running divider, or follow master when slaved
  logic [fdd_pkg::BP_CNT_W-1:0] bp_cnt_ff;
  logic bp_int_ff;
  wire logic bp_wrap = (bp_cnt_ff == fdd_pkg::BP_CNT_W'(fdd_pkg::BP_HALF_CYC - 1));
  wire logic bp_phase = slave_s ? ext_bp_s : bp_int_ff; // RL11

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      bp_cnt_ff <= '0;
      bp_int_ff <= 1'b0;
    end
    else
    begin
      bp_cnt_ff <= bp_wrap ? '0 : bp_cnt_ff + 1'b1;
      bp_int_ff <= bp_wrap ? ~bp_int_ff : bp_int_ff;
    end
  end

  // ==========================================================================
  // Outputs: lit segment is driven opposite to backplane, off segment in phase
  logic [6:0] seg_ff [fdd_pkg::NUM_DIGITS];
  logic bp_ff;
  generate
    for (gi = 0; gi < fdd_pkg::NUM_DIGITS; gi++)
    begin : g_out
      wire logic [6:0] lit_pat = fdd_decode(code_ff[gi]);
      always_ff @(posedge core_clk_in or posedge rst_in)
      begin
        if (rst_in)
          seg_ff[gi] <= fdd_pkg::SEG_OFF;
        else
          seg_ff[gi] <= lit_pat ^ {fdd_pkg::SEG_W{bp_phase}}; // RL10
      end
    end
  endgenerate

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      bp_ff <= 1'b0;
    else
      bp_ff <= bp_phase; // RL10
  end

  assign bp_out = bp_ff;
  assign seg_d1_out = seg_ff[0]; // RL13
  assign seg_d2_out = seg_ff[1];
  assign seg_d3_out = seg_ff[2];
  assign seg_d4_out = seg_ff[3];

  // ==========================================================================
  // Assertions
  a_seg_follows_bp: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL10
    1'b1 |=> (seg_d1_out ^ {7{bp_out}}) == fdd_decode(code_ff[0]) || $changed(code_ff[0]))
    else $error("segment drive out of phase with backplane");
  a_write_latches: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL5
    sel_active && sel_s == 2'h2 |=> code_ff[2] == $past(code_s))
    else $error("selected latch not written");
  a_no_write_idle: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL6
    !sel_active |=> $stable(code_ff[0]) && $stable(code_ff[1]) && $stable(code_ff[2]) && $stable(code_ff[3]))
    else $error("latch changed without both chip selects");
  a_other_hold: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL12
    sel_active && sel_s == 2'h0 |=> $stable(code_ff[3]))
    else $error("unselected latch changed");
  a_blank_off: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL4
    code_ff[3] == fdd_pkg::CODE_BLANK ##1 code_ff[3] == fdd_pkg::CODE_BLANK |-> seg_d4_out == {7{bp_out}})
    else $error("blank digit shows lit segment");
  a_digit_eight: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL2
    code_ff[1] == 4'h8 ##1 code_ff[1] == 4'h8 |-> (seg_d2_out ^ {7{bp_out}}) == fdd_pkg::SEG_8)
    else $error("code eight not decoded");
  a_special_h: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL3
    code_ff[0] == fdd_pkg::CODE_H ##1 code_ff[0] == fdd_pkg::CODE_H |-> (seg_d1_out ^ {7{bp_out}}) == fdd_pkg::SEG_H)
    else $error("code fourteen not decoded as H");
  a_slave_bp: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL11
    slave_s |=> bp_out == $past(ext_bp_s))
    else $error("slaved backplane not following master");
  a_code_order: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL1
    sel_active && sel_s == 2'h1 |=> code_ff[1][0] == $past(sync_ff[0]))
    else $error("data bit order wrong");
  a_seg_d4_phase: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL10
    1'b1 |=> (seg_d4_out ^ {7{bp_out}}) == fdd_decode(code_ff[3]) || $changed(code_ff[3]))
    else $error("digit four drive out of phase with backplane");
  a_free_bp: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL11
    !slave_s |=> bp_out == $past(bp_int_ff))
    else $error("free-running backplane not selected");
  a_special_dash: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL3
    code_ff[2] == fdd_pkg::CODE_DASH ##1 code_ff[2] == fdd_pkg::CODE_DASH |->
    (seg_d3_out ^ {7{bp_out}}) == fdd_pkg::SEG_DASH)
    else $error("code ten not decoded as dash");
  a_sel_d4_hold: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL5
    sel_active && sel_s == 2'h3 |=> $stable(code_ff[0]))
    else $error("digit one changed on write to digit four");
  a_digit_zero: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL2
    code_ff[0] == 4'h0 ##1 code_ff[0] == 4'h0 |-> (seg_d1_out ^ {7{bp_out}}) == fdd_pkg::SEG_0)
    else $error("code zero not decoded");

  c_write_d4: cover property (@(posedge core_clk_in) sel_active && sel_s == 2'h3);
  c_blank: cover property (@(posedge core_clk_in) code_ff[0] == fdd_pkg::CODE_BLANK && !rst_in);
  c_slave: cover property (@(posedge core_clk_in) slave_s && $changed(ext_bp_s));
  c_refused: cover property (@(posedge core_clk_in) !rst_in && (sync_ff[6] ^ sync_ff[7]));
  c_dash: cover property (@(posedge core_clk_in) code_ff[2] == fdd_pkg::CODE_DASH && !rst_in);

endmodule : fdd_write_port

// ===== fdd_host_model.sv
/*
  Host processor model for the display write port: one write cycle per call.
  Assumes the caller waits for each call to return before the next one.
*/
`timescale 1ns/100ps
module fdd_host_model (
  input wire logic clk_in,
  output logic [3:0] code_out,
  output logic [1:0] sel_out,
  output logic cs_n_a_out,
  output logic cs_n_b_out
);
  // ==========================================================================
  // Write cycle: address bits 0 and 1 on the digit selects, strobe and decode
  initial
  begin
    code_out = 4'h0;
    sel_out = 2'h0;
    cs_n_a_out = 1'b1;
    cs_n_b_out = 1'b1;
  end

  task automatic write(input logic [1:0] addr, input logic [3:0] code, input logic [1:0] cs_low);
    @(posedge clk_in);
    code_out <= code;
    sel_out <= addr;
    cs_n_a_out <= ~cs_low[0];
    cs_n_b_out <= ~cs_low[1];
    repeat (5) @(posedge clk_in);
    cs_n_a_out <= 1'b1;
    cs_n_b_out <= 1'b1;
    @(posedge clk_in);
    // Released bus shows the inverse of the last value
    code_out <= ~code;
    sel_out <= ~addr;
    repeat (3) @(posedge clk_in);
  endtask : write
endmodule : fdd_host_model

// ===== tb_top.sv
/*
  Self-checking bench for the display write port, driven through a host model.
  Starts with the backplane slaved to a bench-driven master backplane; t_freerun releases it to run free.
*/
`timescale 1ns/100ps
module tb_top;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic bp_slave_in = 1'b1;
  logic bp_ext_in = 1'b0;
  logic [3:0] code;
  logic [1:0] sel;
  logic cs_a_n;
  logic cs_b_n;
  logic bp_out;
  logic [6:0] segs [4];
  logic [6:0] exp_d [4];
  int fails = 0;
  int total_checks = 0;
  logic [6:0] pat [16] = '{fdd_pkg::SEG_0, fdd_pkg::SEG_1, fdd_pkg::SEG_2, fdd_pkg::SEG_3,
    fdd_pkg::SEG_4, fdd_pkg::SEG_5, fdd_pkg::SEG_6, fdd_pkg::SEG_7, fdd_pkg::SEG_8, fdd_pkg::SEG_9,
    fdd_pkg::SEG_DASH, fdd_pkg::SEG_E, fdd_pkg::SEG_L, fdd_pkg::SEG_P, fdd_pkg::SEG_H, fdd_pkg::SEG_OFF};

  always #10 core_clk_in = ~core_clk_in;

  fdd_host_model host (.clk_in(core_clk_in), .code_out(code), .sel_out(sel), .cs_n_a_out(cs_a_n),
    .cs_n_b_out(cs_b_n));
  fdd_write_port uut (.core_clk_in(core_clk_in), .rst_in(rst_in), .code_in_lsb(code[0]),
    .code_in_b1(code[1]), .code_in_b2(code[2]), .code_in_msb(code[3]), .digit_sel_low(sel[0]),
    .digit_sel_high(sel[1]), .chip_sel_n_a(cs_a_n), .chip_sel_n_b(cs_b_n), .bp_slave_in(bp_slave_in),
    .bp_ext_in(bp_ext_in), .bp_out(bp_out), .seg_d1_out(segs[0]), .seg_d2_out(segs[1]),
    .seg_d3_out(segs[2]), .seg_d4_out(segs[3]));

  // ==========================================================================
  // Shared checks
  task automatic chk_all(input string name);
    @(negedge core_clk_in);
    for (int d = 0; d < 4; d++)
    begin
      total_checks++;
      if ((segs[d] ^ {7{bp_out}}) !== exp_d[d])
      begin
        fails++;
        $display("ERROR %0t %s digit %0d got %h exp %h", $time, name, d, segs[d] ^ {7{bp_out}}, exp_d[d]);
      end
    end
  endtask : chk_all

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // ==========================================================================
  // Scenarios
  task automatic t_codes();
    for (int c = 0; c < 16; c++)
    begin
      host.write(2'(c), 4'(c), 2'h3);
      exp_d[c % 4] = pat[c];
      chk_all("codes");
    end
    $display("codes done");
  endtask : t_codes

  task automatic t_refuse();
    for (int m = 0; m < 3; m++)
    begin
      host.write(2'h1, 4'h8, 2'(m));
      chk_all("refuse");
    end
    $display("refuse done");
  endtask : t_refuse

  task automatic t_backplane();
    int n;
    for (int k = 0; k < 2; k++)
    begin
      @(posedge core_clk_in);
      bp_ext_in <= ~bp_ext_in;
      n = 0;
      @(posedge core_clk_in);
      while (bp_out !== bp_ext_in && n < 8)
      begin
        @(posedge core_clk_in);
        n++;
      end
      total_checks++;
      if (bp_out !== bp_ext_in)
      begin
        fails++;
        $display("ERROR %0t backplane does not follow master", $time);
      end
      chk_all("backplane");
    end
    $display("backplane done");
  endtask : t_backplane

  task automatic t_freerun();
    @(posedge core_clk_in);
    bp_ext_in <= 1'b1;
    repeat (6) @(posedge core_clk_in);
    bp_slave_in <= 1'b0;
    repeat (6) @(posedge core_clk_in);
    // Divider has run far fewer than fdd_pkg::BP_HALF_CYC cycles, so its phase is still low
    chk_all("freerun");
    total_checks++;
    if (bp_out !== 1'b0)
    begin
      fails++;
      $display("ERROR %0t free-running backplane not selected", $time);
    end
    $display("freerun done");
  endtask : t_freerun

  initial
  begin
    for (int d = 0; d < 4; d++)
      exp_d[d] = fdd_pkg::SEG_OFF;
    repeat (4) @(posedge core_clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    chk_all("reset");
    $display("reset done");
    t_codes();
    t_refuse();
    t_backplane();
    t_freerun();
    test_done();
  end
endmodule : tb_top
